// ==== verilog/mts_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mts_map.svh"
module mts_sequencer
   import mts_pkg::*;
#(
   parameter int MS_CYCLES = `MTS_MS_NS / `MTS_CLK_PERIOD_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mot_ready,
   input wire logic mot_busy,
   input wire logic mot_done,
   output logic mot_start,
   output logic [15:0] mot_op,
   output logic [31:0] mot_target,
   output logic [31:0] mot_center,
   output logic mot_chain
);
   mts_regs_t seq;
   mts_regs_t next_seq;
   mts_row_t rd_row;
   logic wr_acc;
   logic start_wr;
   logic stop_wr;
   logic moff_wr;
   logic [31:0] tgt;

   function automatic logic is_after(input logic [15:0] c);
      return c <= `MTS_MC_AFTER_MAX;
   endfunction

   function automatic logic is_with(input logic [15:0] c);
      return c >= `MTS_MC_WITH_MIN && c <= `MTS_MC_WITH_MAX;
   endfunction

   function automatic logic is_interp(input logic [15:0] op);
      return op == `MTS_OP_LIN || op == `MTS_OP_CIRC;
   endfunction

   function automatic logic [8:0] inc_row(input logic [8:0] r);
      return r + 9'h001;
   endfunction

   function automatic mts_state_t adv_st(input logic [8:0] r);
      return (r == `MTS_LAST_ROW) ? MTS_IDLE : MTS_FETCH;
   endfunction

   function automatic logic is_mapped(input logic [11:0] a);
      return a[1:0] == 2'h0 && a <= `MTS_REG_TBL_WRITE;
   endfunction

   mts_table_mem u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(seq.wr_en),
      .wr_addr(seq.wr_idx),
      .wr_data(seq.stg),
      .rd_addr(seq.row),
      .rd_data(rd_row)
   );

   // no wait states: read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !is_mapped(paddr);
   assign wr_acc = psel && penable && pwrite && is_mapped(paddr);
   assign start_wr = wr_acc && paddr == `MTS_REG_CTRL && pwdata[`MTS_CTRL_START];
   assign stop_wr = wr_acc && paddr == `MTS_REG_CTRL && pwdata[`MTS_CTRL_STOP];
   assign moff_wr = wr_acc && paddr == `MTS_REG_CTRL && pwdata[`MTS_CTRL_MOFF];
   assign tgt = seq.absm ? rd_row.pos : seq.cur_addr + rd_row.pos;

   always_comb begin
      next_seq = seq;
      next_seq.mot_start = 1'b0;
      next_seq.wr_en = 1'b0;
      if (psel && !penable) begin
         unique case (paddr)
            `MTS_REG_STATUS: begin
               next_seq.prdata = '0;
               next_seq.prdata[`MTS_STAT_BUSY] = seq.st != MTS_IDLE;
               next_seq.prdata[`MTS_STAT_ABS] = seq.absm;
               next_seq.prdata[`MTS_STAT_DWELL] = seq.st == MTS_DWELL;
               next_seq.prdata[`MTS_STAT_MWAIT] = seq.st == MTS_MWAIT;
               next_seq.prdata[`MTS_STAT_MCODE_ON] = seq.mflag;
            end
            `MTS_REG_MCODE_NUM: next_seq.prdata = {{16{seq.mnum[15]}}, seq.mnum};
            `MTS_REG_TABLE_NUM: next_seq.prdata = {23'h000000, seq.row};
            `MTS_REG_CUR_ADDR: next_seq.prdata = seq.cur_addr;
            `MTS_REG_START_ROW: next_seq.prdata = {23'h000000, seq.start_row};
            `MTS_REG_ITC: next_seq.prdata = {16'h0000, seq.itc};
            default: next_seq.prdata = '0;
         endcase
      end
      if (wr_acc) begin
         unique case (paddr)
            `MTS_REG_CUR_ADDR: next_seq.cur_addr = pwdata;
            `MTS_REG_START_ROW: next_seq.start_row = pwdata[8:0];
            `MTS_REG_ITC: next_seq.itc = pwdata[15:0];
            `MTS_REG_TBL_POS: next_seq.stg.pos = pwdata;
            `MTS_REG_TBL_AUX: next_seq.stg.aux = pwdata;
            `MTS_REG_TBL_OPM: begin
               next_seq.stg.op = pwdata[15:0];
               next_seq.stg.mcode = pwdata[31:16];
            end
            `MTS_REG_TBL_TIME: next_seq.stg.time_ms = pwdata[15:0];
            `MTS_REG_TBL_WRITE: begin
               next_seq.wr_idx = pwdata[8:0];
               next_seq.wr_en = pwdata[8:0] <= `MTS_LAST_ROW;
            end
            default: ;
         endcase
      end
      // clear first so that an activation in the same cycle wins
      if (moff_wr) begin
         next_seq.mflag = 1'b0;
         next_seq.mnum = `MTS_MC_NONE;
      end
      unique case (seq.st)
         MTS_IDLE: begin
            if (start_wr) begin
               next_seq.row = seq.start_row;
               next_seq.absm = 1'b1;
               next_seq.mot_chain = 1'b0;
               next_seq.st = MTS_FETCH;
               if (seq.mnum == `MTS_MC_AFTER_STBY || seq.mnum == `MTS_MC_WITH_MIN) begin
                  next_seq.mflag = 1'b0;
                  next_seq.mnum = `MTS_MC_NONE;
               end
            end
         end
         MTS_FETCH: next_seq.st = MTS_EXEC;
         MTS_EXEC: begin
            unique case (rd_row.op)
               `MTS_OP_NONE: begin
                  next_seq.row = inc_row(seq.row);
                  next_seq.st = adv_st(seq.row);
               end
               `MTS_OP_END: begin
                  if (!mot_busy) begin
                     next_seq.st = MTS_IDLE;
                     next_seq.mot_chain = 1'b0;
                  end
               end
               `MTS_OP_JUMP: begin
                  // one table only, so a jump past the last row ends the run in idle
                  next_seq.row = rd_row.pos[8:0];
                  next_seq.st = (rd_row.pos > 32'(`MTS_LAST_ROW)) ? MTS_IDLE : MTS_FETCH;
               end
               `MTS_OP_CPC: begin
                  next_seq.cur_addr = rd_row.pos;
                  next_seq.row = inc_row(seq.row);
                  next_seq.st = adv_st(seq.row);
               end
               `MTS_OP_ABS, `MTS_OP_REL: begin
                  next_seq.absm = rd_row.op == `MTS_OP_ABS;
                  next_seq.row = inc_row(seq.row);
                  next_seq.st = adv_st(seq.row);
               end
               `MTS_OP_DWELL: begin
                  if (!mot_busy) begin
                     next_seq.dwell_cnt = rd_row.pos;
                     next_seq.ms_cnt = '0;
                     next_seq.mot_chain = 1'b0;
                     next_seq.st = MTS_DWELL;
                  end
               end
               `MTS_OP_MCODE: begin
                  if (!mot_busy) begin
                     next_seq.row_m = rd_row.mcode;
                     if (rd_row.mcode == `MTS_MC_NONE) begin
                        next_seq.row = inc_row(seq.row);
                        next_seq.st = adv_st(seq.row);
                     end else begin
                        next_seq.mflag = 1'b1;
                        next_seq.mnum = rd_row.mcode;
                        next_seq.mot_chain = 1'b0;
                        next_seq.st = MTS_MWAIT;
                     end
                  end
               end
               default: begin
                  if (is_interp(rd_row.op) ? mot_ready : !mot_busy) begin
                     next_seq.mot_start = 1'b1;
                     next_seq.mot_op = rd_row.op;
                     next_seq.mot_target = tgt;
                     next_seq.mot_center = rd_row.aux;
                     next_seq.cur_addr = tgt;
                     next_seq.row_m = rd_row.mcode;
                     next_seq.mot_chain = is_interp(rd_row.op) && !is_after(rd_row.mcode)
                        && rd_row.time_ms > `MTS_CP_MIN_MS
                        && 17'(rd_row.time_ms) > {seq.itc, 1'b0};
                     if (is_with(rd_row.mcode)) begin
                        next_seq.mflag = 1'b1;
                        next_seq.mnum = rd_row.mcode;
                     end
                     if (next_seq.mot_chain) begin
                        next_seq.row = inc_row(seq.row);
                        next_seq.st = adv_st(seq.row);
                     end else begin
                        next_seq.st = MTS_MOVE;
                     end
                  end
               end
            endcase
         end
         MTS_MOVE: begin
            if (mot_done) begin
               if (is_after(seq.row_m)) begin
                  next_seq.mflag = 1'b1;
                  next_seq.mnum = seq.row_m;
                  next_seq.st = MTS_MWAIT;
               end else if (is_with(seq.row_m) && next_seq.mflag) begin
                  next_seq.st = MTS_MWAIT;
               end else begin
                  next_seq.row = inc_row(seq.row);
                  next_seq.st = adv_st(seq.row);
               end
            end
         end
         MTS_DWELL: begin
            if (seq.dwell_cnt == '0 || seq.dwell_cnt[31]) begin
               next_seq.row = inc_row(seq.row);
               next_seq.st = adv_st(seq.row);
            end else if (seq.ms_cnt == 17'(MS_CYCLES - 1)) begin
               next_seq.ms_cnt = '0;
               next_seq.dwell_cnt = seq.dwell_cnt - 32'h00000001;
            end else begin
               next_seq.ms_cnt = seq.ms_cnt + 17'h00001;
            end
         end
         MTS_MWAIT: begin
            if (moff_wr || (start_wr && (seq.row_m == `MTS_MC_AFTER_STBY
                  || seq.row_m == `MTS_MC_WITH_MIN))) begin
               next_seq.mflag = 1'b0;
               next_seq.mnum = `MTS_MC_NONE;
               next_seq.row = inc_row(seq.row);
               next_seq.st = adv_st(seq.row);
            end
         end
      endcase
      if (stop_wr) begin
         next_seq.st = MTS_IDLE;
         next_seq.mot_chain = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq <= '0;
         seq.st <= MTS_IDLE;
         seq.absm <= 1'b1;
         seq.mnum <= `MTS_MC_NONE;
         seq.row_m <= `MTS_MC_NONE;
         seq.stg <= '1;
      end else begin
         seq <= next_seq;
      end
   end

   assign prdata = seq.prdata;
   assign mot_start = seq.mot_start;
   assign mot_op = seq.mot_op;
   assign mot_target = seq.mot_target;
   assign mot_center = seq.mot_center;
   assign mot_chain = seq.mot_chain;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_cpc_load: assert property (
      seq.st == MTS_EXEC && rd_row.op == `MTS_OP_CPC && !wr_acc && !stop_wr
      |=> seq.cur_addr == $past(rd_row.pos))
      else $error("position change not loaded");
   chk_abs_default: assert property (
      seq.st == MTS_IDLE && start_wr && !stop_wr |=> seq.absm && seq.st == MTS_FETCH)
      else $error("start did not select absolute");
   chk_rel_target: assert property (
      seq.st == MTS_EXEC && next_seq.mot_start && !seq.absm
      |=> mot_start && mot_target == $past(seq.cur_addr) + $past(rd_row.pos))
      else $error("relative target wrong");
   chk_jump_row: assert property (
      seq.st == MTS_EXEC && rd_row.op == `MTS_OP_JUMP && rd_row.pos <= 32'(`MTS_LAST_ROW)
      && !stop_wr |=> seq.row == $past(rd_row.pos[8:0]) ##1 seq.st == MTS_EXEC)
      else $error("jump went astray");
   chk_with_act: assert property (
      seq.st == MTS_EXEC && next_seq.mot_start && is_with(rd_row.mcode)
      |=> seq.mflag && seq.mnum == $past(rd_row.mcode))
      else $error("concurrent code not active at start");
   chk_after_late: assert property (
      seq.st == MTS_MOVE && mot_done && is_after(seq.row_m) && !stop_wr
      |=> seq.mflag && seq.st == MTS_MWAIT && seq.mnum == $past(seq.row_m))
      else $error("post-step code not raised");
   chk_mwait_hold: assert property (
      seq.st == MTS_MWAIT && !moff_wr && !start_wr && !stop_wr |=> seq.st == MTS_MWAIT)
      else $error("left code wait without off");
   chk_moff_clear: assert property (
      seq.st == MTS_MWAIT && moff_wr |=> !seq.mflag && seq.mnum == `MTS_MC_NONE)
      else $error("code off did not clear");
   chk_chain_gate: assert property (
      seq.st == MTS_EXEC && next_seq.mot_start
      && (is_after(rd_row.mcode) || rd_row.time_ms <= `MTS_CP_MIN_MS) |=> !mot_chain)
      else $error("chain not disabled");
endmodule
`default_nettype wire

// ==== verilog/mts_map.svh ====
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH
// register byte offsets
`define MTS_REG_CTRL 12'h000
`define MTS_REG_STATUS 12'h004
`define MTS_REG_MCODE_NUM 12'h008
`define MTS_REG_TABLE_NUM 12'h00c
`define MTS_REG_CUR_ADDR 12'h010
`define MTS_REG_START_ROW 12'h014
`define MTS_REG_ITC 12'h018
`define MTS_REG_TBL_POS 12'h01c
`define MTS_REG_TBL_AUX 12'h020
`define MTS_REG_TBL_OPM 12'h024
`define MTS_REG_TBL_TIME 12'h028
`define MTS_REG_TBL_WRITE 12'h02c
// control and status bits
`define MTS_CTRL_START 0
`define MTS_CTRL_STOP 1
`define MTS_CTRL_MOFF 11
`define MTS_STAT_BUSY 0
`define MTS_STAT_ABS 1
`define MTS_STAT_DWELL 2
`define MTS_STAT_MWAIT 3
`define MTS_STAT_MCODE_ON 8
// operation codes
`define MTS_OP_NONE 16'hffff
`define MTS_OP_END 16'h0000
`define MTS_OP_LIN 16'h000a
`define MTS_OP_CIRC 16'h000b
`define MTS_OP_DWELL 16'h0010
`define MTS_OP_JUMP 16'h0011
`define MTS_OP_CPC 16'h0012
`define MTS_OP_ABS 16'h0013
`define MTS_OP_REL 16'h0014
`define MTS_OP_MCODE 16'h0015
// auxiliary code ranges
`define MTS_MC_NONE 16'hffff
`define MTS_MC_AFTER_MAX 16'h270f
`define MTS_MC_WITH_MIN 16'h2710
`define MTS_MC_WITH_MAX 16'h7fff
`define MTS_MC_AFTER_STBY 16'h0000
// table size
`define MTS_ROWS 300
`define MTS_LAST_ROW 9'h12b
// timing
`define MTS_CLK_PERIOD_NS 8
`define MTS_MS_NS 1000000
`define MTS_CP_MIN_MS 16'h0032
`endif

// ==== verilog/mts_pkg.sv ====
package mts_pkg;
   typedef enum logic [5:0] {
      MTS_IDLE = 6'h01,
      MTS_FETCH = 6'h02,
      MTS_EXEC = 6'h04,
      MTS_MOVE = 6'h08,
      MTS_DWELL = 6'h10,
      MTS_MWAIT = 6'h20
   } mts_state_t;

   typedef struct packed {
      logic [31:0] pos;
      logic [31:0] aux;
      logic [15:0] op;
      logic [15:0] mcode;
      logic [15:0] time_ms;
   } mts_row_t;

   typedef struct packed {
      mts_state_t st;
      logic [8:0] row;
      logic [8:0] start_row;
      logic [31:0] cur_addr;
      logic absm;
      logic mflag;
      logic [15:0] mnum;
      logic [15:0] row_m;
      logic [31:0] dwell_cnt;
      logic [16:0] ms_cnt;
      logic [15:0] itc;
      mts_row_t stg;
      logic wr_en;
      logic [8:0] wr_idx;
      logic [31:0] prdata;
      logic mot_start;
      logic [15:0] mot_op;
      logic [31:0] mot_target;
      logic [31:0] mot_center;
      logic mot_chain;
   } mts_regs_t;
endpackage

// ==== verilog/mts_table_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mts_map.svh"
module mts_table_mem
   import mts_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [8:0] wr_addr,
   input wire mts_row_t wr_data,
   input wire logic [8:0] rd_addr,
   output mts_row_t rd_data
);
   mts_row_t mem [0:`MTS_ROWS-1];
   logic [`MTS_ROWS-1:0] valid;

   // valid bits stand in for resetting the whole array
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid <= '0;
      end else if (wr_en) begin
         valid[wr_addr] <= 1'b1;
      end
   end

   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '1;
      end else if (valid[rd_addr]) begin
         rd_data <= mem[rd_addr];
      end else begin
         rd_data <= '1;
      end
   end
endmodule
`default_nettype wire

// ==== tb/mts_motion_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// behavioural motion generator; slow stretches each move so the host can poll mid-motion
module mts_motion_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mot_start,
   input wire logic mot_chain,
   input wire logic slow,
   output logic mot_ready,
   output logic mot_busy,
   output var logic mot_done
);
   logic [5:0] cnt;
   logic chn;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 6'h00;
         chn <= 1'b0;
         mot_done <= 1'b0;
      end else begin
         mot_done <= 1'b0;
         if (mot_start) begin
            cnt <= slow ? 6'h28 : 6'h03;
            chn <= mot_chain;
         end else if (cnt != 6'h00) begin
            cnt <= cnt - 6'h01;
            // a blended segment never reports completion, the next one takes over
            if (cnt == 6'h01 && !chn) begin
               mot_done <= 1'b1;
            end
         end
      end
   end
   assign mot_busy = (cnt != 6'h00);
   assign mot_ready = (cnt == 6'h00) || chn;
endmodule
`default_nettype wire

// ==== tb/motion_table_step_sequencer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mts_map.svh"
module motion_table_step_sequencer_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic slow = 1'b0;
   logic [31:0] prdata, mot_target, mot_center, q, tgt, ctr;
   logic pready, pslverr, mot_ready, mot_busy, mot_done, mot_start, mot_chain, e;
   int n_chn = 0;
   logic [15:0] mot_op, opv;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   int n_start = 0;
   int t_go = 0;
   int t_mv = 0;
   int k, i;
   logic [15:0] tt[3] = '{16'h0064, 16'h0028, 16'h0064};
   logic [15:0] it[3] = '{16'h000a, 16'h000a, 16'h003c};

   mts_sequencer #(.MS_CYCLES(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mot_ready(mot_ready), .mot_busy(mot_busy),
      .mot_done(mot_done), .mot_start(mot_start), .mot_op(mot_op), .mot_target(mot_target),
      .mot_center(mot_center), .mot_chain(mot_chain));
   mts_motion_model pm (.pclk(pclk), .presetn(presetn), .mot_start(mot_start),
      .mot_chain(mot_chain), .slow(slow), .mot_ready(mot_ready), .mot_busy(mot_busy),
      .mot_done(mot_done));

   initial begin
      forever #4 pclk = ~pclk;
   end

   task automatic conclude();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (mot_start === 1'b1) begin
         n_start <= n_start + 1;
         tgt <= mot_target;
         ctr <= mot_center;
         t_mv <= cyc;
         opv <= mot_op;
         if (mot_chain === 1'b1) n_chn <= n_chn + 1;
      end
      // generous ceiling, the whole sequence needs well under a third of it
      if (cyc == 60000) begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, x, s);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic row(input int n, input logic [31:0] p, input logic [31:0] x,
      input logic [15:0] op, input logic [15:0] mc, input logic [15:0] tm);
      wr(`MTS_REG_TBL_POS, p);
      wr(`MTS_REG_TBL_AUX, x);
      wr(`MTS_REG_TBL_OPM, {mc, op});
      wr(`MTS_REG_TBL_TIME, {16'h0, tm});
      wr(`MTS_REG_TBL_WRITE, 32'(n));
   endtask

   task automatic fin(input int n);
      row(n, 32'h0, 32'h0, `MTS_OP_END, `MTS_MC_NONE, 16'h0);
   endtask

   task automatic go();
      wr(`MTS_REG_CTRL, 32'h1);
      t_go = cyc;
   endtask

   // polling keeps the wait bounded without assuming any latency
   task automatic wait_bit(input int b, input logic v);
      for (int j = 0; j < 3000; j++) begin
         rd(`MTS_REG_STATUS);
         if (q[b] === v) break;
      end
   endtask

   task automatic moff();
      wr(`MTS_REG_CTRL, 32'h800);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(`MTS_REG_STATUS); chk("status", q, 32'h2);
      rd(`MTS_REG_MCODE_NUM); chk("mnum", q, 32'hffffffff);
      rd(12'h030); chk("slverr", {31'h0, e}, 32'h1);
      chk("bad rd", q, 32'h0);
      go(); wait_bit(0, 1'b0); chk("blank starts", 32'(n_start), 32'h0);
      slow <= 1'b1;
      row(0, 32'd100, 32'h0, 16'h0001, 16'd10, 16'h0); fin(1);
      go(); wait (n_start == 1);
      rd(`MTS_REG_STATUS); chk("flag early", {31'h0, q[8]}, 32'h0);
      wait_bit(3, 1'b1); chk("tgt", tgt, 32'd100);
      rd(`MTS_REG_MCODE_NUM); chk("mnum", q, 32'd10);
      rd(`MTS_REG_STATUS); chk("flag", {31'h0, q[`MTS_STAT_MCODE_ON]}, 32'h1);
      rd(`MTS_REG_TABLE_NUM); chk("row", q, 32'h0);
      moff(); wait_bit(0, 1'b0);
      rd(`MTS_REG_MCODE_NUM); chk("mnum off", q, 32'hffffffff);
      rd(`MTS_REG_STATUS); chk("flag off", {31'h0, q[8]}, 32'h0);
      slow <= 1'b0;
      wr(`MTS_REG_CUR_ADDR, 32'd100);
      row(0, 32'h0, 32'h0, `MTS_OP_REL, `MTS_MC_NONE, 16'h0);
      row(1, 32'd50, 32'h0, 16'h0001, `MTS_MC_NONE, 16'h0); fin(2);
      row(3, 32'd40, 32'd25, 16'h0001, `MTS_MC_NONE, 16'h0); fin(4);
      go(); wait_bit(0, 1'b0); chk("rel tgt", tgt, 32'd150);
      wr(`MTS_REG_START_ROW, 32'd3);
      go(); wait_bit(0, 1'b0); chk("abs tgt", tgt, 32'd40);
      chk("center", ctr, 32'd25);
      wr(`MTS_REG_START_ROW, 32'd0);
      row(1, 32'h0, 32'h0, `MTS_OP_ABS, `MTS_MC_NONE, 16'h0);
      row(2, 32'd70, 32'h0, 16'h0001, `MTS_MC_NONE, 16'h0); fin(3);
      go(); wait_bit(0, 1'b0); chk("abs item", tgt, 32'd70);
      row(0, 32'd777, 32'h0, `MTS_OP_CPC, `MTS_MC_NONE, 16'h0); fin(1);
      go(); wait_bit(0, 1'b0);
      rd(`MTS_REG_CUR_ADDR); chk("cur addr", q, 32'd777);
      row(0, 32'd5, 32'h0, `MTS_OP_JUMP, `MTS_MC_NONE, 16'h0);
      row(5, 32'd3, 32'h0, `MTS_OP_DWELL, `MTS_MC_NONE, 16'h0);
      row(6, 32'd9, 32'h0, 16'h0001, `MTS_MC_NONE, 16'h0); fin(7);
      go(); wait_bit(`MTS_STAT_DWELL, 1'b1);
      chk("dwelling", {31'h0, q[`MTS_STAT_DWELL]}, 32'h1);
      wait_bit(0, 1'b0); chk("jump tgt", tgt, 32'd9);
      chk("dwell", {31'h0, (t_mv - t_go) >= 30}, 32'h1);
      slow <= 1'b1;
      k = n_start;
      row(0, 32'd10, 32'h0, 16'h0001, 16'd10010, 16'h0);
      row(1, 32'd20, 32'h0, 16'h0001, `MTS_MC_NONE, 16'h0); fin(2);
      go(); wait (n_start == k + 1);
      rd(`MTS_REG_MCODE_NUM); chk("with num", q, 32'd10010);
      wait_bit(3, 1'b1); chk("held", 32'(n_start), 32'(k + 1));
      moff(); wait_bit(0, 1'b0); chk("after off", tgt, 32'd20);
      slow <= 1'b0;
      for (i = 0; i < 3; i++) begin
         wr(`MTS_REG_ITC, {16'h0, it[i]});
         row(0, 32'd10, 32'h0, `MTS_OP_LIN, `MTS_MC_NONE, tt[i]);
         row(1, 32'h0, 32'h0, `MTS_OP_NONE, `MTS_MC_NONE, 16'h0);
         row(2, 32'd20, 32'd5, `MTS_OP_CIRC, `MTS_MC_NONE, tt[i]); fin(3);
         k = n_chn;
         go(); wait_bit(0, 1'b0);
         chk("chain", {31'h0, n_chn != k}, {31'h0, i == 0});
         chk("op", {16'h0, opv}, {16'h0, `MTS_OP_CIRC});
      end
      k = n_start;
      row(0, 32'h0, 32'h0, `MTS_OP_MCODE, 16'h0000, 16'h0); fin(1);
      go(); wait_bit(3, 1'b1); chk("no motion", 32'(n_start), 32'(k));
      rd(`MTS_REG_MCODE_NUM); chk("stby num", q, 32'h0);
      go(); wait_bit(0, 1'b0);
      rd(`MTS_REG_MCODE_NUM); chk("stby clr", q, 32'hffffffff);
      // stop must return the sequencer to idle at once during a running move
      slow <= 1'b1;
      k = n_start;
      row(0, 32'd10, 32'h0, 16'h0001, `MTS_MC_NONE, 16'h0); fin(1);
      go(); wait (n_start == k + 1);
      wr(`MTS_REG_CTRL, 32'h2);
      rd(`MTS_REG_STATUS); chk("stopped", {31'h0, q[`MTS_STAT_BUSY]}, 32'h0);
      conclude();
   end
endmodule
`default_nettype wire
